// ==== hdl/acc_pkg.sv ====
// package: register layout, field positions, reset values and mode codes of the calibration control block
package acc_pkg;
  localparam int unsigned REG_W = 8;
  // calibration_control bit positions
  localparam int unsigned CC_OUTSEQ = 6;
  localparam int unsigned CC_SYNC   = 5;
  localparam int unsigned CC_CALSEL = 4;
  localparam int unsigned CC_BYP_SYS_GAIN  = 3;
  localparam int unsigned CC_BYP_SYS_OFFS  = 2;
  localparam int unsigned CC_BYP_SELF_GAIN = 1;
  localparam int unsigned CC_BYP_SELF_OFFS = 0;
  localparam logic [7:0]  CC_RESET  = 8'h1C;
  localparam logic [7:0]  CC_WMASK  = 8'h7F;
  // amplifier control: enable bit and 3-bit gain code
  localparam int unsigned AMP_EN_BIT = 3;
  localparam logic [3:0]  AMP_RESET  = 4'h0;
  localparam logic [7:0]  GAIN_ONE   = 8'h01;
  // register selects on the documented port
  localparam logic [1:0]  SEL_CAL    = 2'h0;
  localparam logic [1:0]  SEL_AMP    = 2'h1;
  localparam logic [1:0]  SEQ_MODE3  = 2'h3;
  localparam int unsigned NPIN       = 6;
  localparam int unsigned NCH        = 6;
  localparam int unsigned COEF_W     = 24;
  localparam logic [5:0]  PINS_ZERO  = 6'h00;

  typedef struct packed {
    logic outSeqSelect;
    logic syncEnable;
    logic calReadbackSelect;
    logic bypassSystemGain;
    logic bypassSystemOffset;
    logic bypassSelfGain;
    logic bypassSelfOffset;
  } acc_cal_ctrl_t;

  typedef struct packed {
    logic useSystemGain;
    logic useSystemOffset;
    logic useSelfGain;
    logic useSelfOffset;
  } acc_coef_use_t;
endpackage

// ==== hdl/acc_pin_map.sv ====
// small memory: per-channel output pin pattern used while sequencing, registered read
module acc_pin_map (
  input  wire logic       mclk,    // clock
  input  wire logic       rst,     // async reset
  input  wire logic       wrEn,    // write strobe
  input  wire logic [2:0] wrAddr,  // channel written
  input  wire logic [5:0] wrData,  // pin pattern
  input  wire logic [2:0] rdAddr,  // channel read
  output logic      [5:0] rdData   // registered pattern
);
  logic [5:0] mem [acc_pkg::NCH];

  always_ff @(posedge mclk) begin
    if (wrEn && wrAddr < 3'(acc_pkg::NCH)) begin
      mem[wrAddr] <= wrData;
    end
  end

  // out-of-range channel reads zero rather than stale contents
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData <= acc_pkg::PINS_ZERO;
    end else if (rdAddr < 3'(acc_pkg::NCH)) begin
      rdData <= mem[rdAddr];
    end else begin
      rdData <= acc_pkg::PINS_ZERO;
    end
  end
endmodule // acc_pin_map

// ==== hdl/acc_calibration_control_regs.sv ====
// calibration and operation control register, amplifier gain code and pin output steering
// Notes on behaviour
// - sequencer mode 3 with sequencing select set: pins follow per-channel map entries.
// - sequencing select clear: pins driven directly from direction and GPIO control values.
// - in sequencer modes 1 and 2 the sequencing select bit changes nothing.
// - sync-enable bit one turns synchronization mode on, zero turns it off.
// - coefficient read returns interface value if select is one, internal value if zero.
// - system gain bypass one omits the system gain coefficient, zero applies it.
// - system offset bypass one excludes the system offset coefficient, zero includes it.
// - self gain bypass one leaves out the self gain coefficient, zero applies it.
// - self offset bypass one leaves out the self offset coefficient, zero applies it.
// - calibration control register is read/write; a read returns bits 6:0 of the last value written, bit 7 reads zero.
// - gain code acts only while amplifier enable is one; zero disables the amplifier.
module acc_calibration_control_regs (
  input  wire logic                              mclk,          // 20 MHz clock
  input  wire logic                              rst,           // async reset, high
  input  wire logic                              regWrite,      // one-cycle write strobe
  input  wire logic                              regRead,       // one-cycle read strobe
  input  wire logic [1:0]                        regSel,        // register select
  input  wire logic [7:0]                        regWdata,      // write data
  output logic      [7:0]                        regRdata,      // read data, one cycle after strobe
  input  wire logic [1:0]                        seqMode,       // sequencer mode 1..3
  input  wire logic [2:0]                        activeChannel, // channel now converting
  input  wire logic                              mapWrite,      // channel map entry write
  input  wire logic [2:0]                        mapChannel,    // channel map index
  input  wire logic [5:0]                        mapPins,       // pins for that channel
  input  wire logic [5:0]                        directPins,    // direction and GPIO ctrl values
  input  wire logic                              coefRead,      // coefficient read strobe
  input  wire logic [acc_pkg::COEF_W-1:0]        coefIface,     // interface-side coefficient
  input  wire logic [acc_pkg::COEF_W-1:0]        coefInternal,  // internally held coefficient
  output logic      [acc_pkg::COEF_W-1:0]        coefRdata,     // coefficient readback
  output logic      [5:0]                        general_output_pins, // steered output pins
  output logic                                   syncModeOn,    // synchronization mode active
  output acc_pkg::acc_coef_use_t                 coefUse,       // coefficient apply flags
  output logic                                   ampEnabled,    // amplifier running
  output logic      [7:0]                        ampGain        // linear gain 1..128
);
  acc_pkg::acc_cal_ctrl_t calibration_control_q;
  logic                   amp_enable_q;
  logic [2:0]             amp_gain_code_q;
  logic [5:0]             mapPinsRd;
  logic                   seqActive;

  // register write path
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      calibration_control_q <= acc_pkg::acc_cal_ctrl_t'(acc_pkg::CC_RESET[6:0]);
    end else if (regWrite && regSel == acc_pkg::SEL_CAL) begin
      calibration_control_q <= acc_pkg::acc_cal_ctrl_t'(regWdata[6:0]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      amp_enable_q    <= acc_pkg::AMP_RESET[acc_pkg::AMP_EN_BIT];
      amp_gain_code_q <= acc_pkg::AMP_RESET[2:0];
    end else if (regWrite && regSel == acc_pkg::SEL_AMP) begin
      amp_enable_q    <= regWdata[acc_pkg::AMP_EN_BIT];
      amp_gain_code_q <= regWdata[2:0];
    end
  end

  // readback; unmapped selects read zero, top bit always zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regSel)
        acc_pkg::SEL_CAL: regRdata <= {1'b0, calibration_control_q};
        acc_pkg::SEL_AMP: regRdata <= {4'h0, amp_enable_q, amp_gain_code_q};
        default:          regRdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      coefRdata <= '0;
    end else if (coefRead) begin
      coefRdata <= calibration_control_q.calReadbackSelect ? coefIface : coefInternal;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncModeOn <= 1'b0;
      // flags already match the reset register so they agree with it straight out of reset; after a write they lag it by one cycle
      coefUse    <= acc_pkg::acc_coef_use_t'(~acc_pkg::CC_RESET[3:0]);
    end else begin
      syncModeOn              <= calibration_control_q.syncEnable;
      coefUse.useSystemGain   <= ~calibration_control_q.bypassSystemGain;
      coefUse.useSystemOffset <= ~calibration_control_q.bypassSystemOffset;
      coefUse.useSelfGain     <= ~calibration_control_q.bypassSelfGain;
      coefUse.useSelfOffset   <= ~calibration_control_q.bypassSelfOffset;
    end
  end

  // a disabled amplifier reports unity so downstream never scales by a stale code
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ampEnabled <= 1'b0;
      ampGain    <= acc_pkg::GAIN_ONE;
    end else begin
      ampEnabled <= amp_enable_q;
      ampGain    <= amp_enable_q ? (acc_pkg::GAIN_ONE << amp_gain_code_q) : acc_pkg::GAIN_ONE;
    end
  end

  acc_pin_map uMap (
    .mclk   (mclk),
    .rst    (rst),
    .wrEn   (mapWrite),
    .wrAddr (mapChannel),
    .wrData (mapPins),
    .rdAddr (activeChannel),
    .rdData (mapPinsRd)
  );

  // sequencing only in mode 3; select bit ignored elsewhere
  assign seqActive = (seqMode == acc_pkg::SEQ_MODE3) && calibration_control_q.outSeqSelect;

  // map read is one cycle late; pins settle two cycles after a channel change
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      general_output_pins <= acc_pkg::PINS_ZERO;
    end else if (seqActive) begin
      general_output_pins <= mapPinsRd;
    end else begin
      general_output_pins <= directPins;
    end
  end

  // register port
  a_sync_follows: assert property (@(posedge mclk) disable iff (rst)
    syncModeOn == $past(calibration_control_q.syncEnable))
    else $error("sync mode does not follow enable bit");
  a_sync_off: assert property (@(posedge mclk) disable iff (rst)
    !calibration_control_q.syncEnable |=> !syncModeOn)
    else $error("sync mode on while enable bit clear");
  a_cal_readback: assert property (@(posedge mclk) disable iff (rst)
    regRead && regSel == acc_pkg::SEL_CAL && !regWrite |=> regRdata[6:0] == $past(calibration_control_q))
    else $error("control readback mismatch");
  a_write_then_read: assert property (@(posedge mclk) disable iff (rst)
    regWrite && regSel == acc_pkg::SEL_CAL ##1 regRead && regSel == acc_pkg::SEL_CAL && !regWrite
    |=> regRdata == {1'b0, $past(regWdata[6:0], 2)})
    else $error("read does not return last write");
  a_rdata_top_bit: assert property (@(posedge mclk) disable iff (rst)
    regRead |=> !regRdata[7])
    else $error("top bit of readback not zero");
  a_rdata_holds: assert property (@(posedge mclk) disable iff (rst)
    !regRead |=> $stable(regRdata))
    else $error("read data changed without a read");
  a_cal_write_only: assert property (@(posedge mclk) disable iff (rst)
    !(regWrite && regSel == acc_pkg::SEL_CAL) |=> $stable(calibration_control_q))
    else $error("control register changed without a write");
  a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst)
    regRead && regSel != acc_pkg::SEL_CAL && regSel != acc_pkg::SEL_AMP |=> regRdata == 8'h00)
    else $error("unmapped select did not read zero");

  // coefficient readback and apply flags
  a_coef_select: assert property (@(posedge mclk) disable iff (rst)
    coefRead |=> coefRdata == ($past(calibration_control_q.calReadbackSelect) ?
                               $past(coefIface) : $past(coefInternal)))
    else $error("coefficient readback wrong source");
  a_coef_holds: assert property (@(posedge mclk) disable iff (rst)
    !coefRead |=> $stable(coefRdata))
    else $error("coefficient readback changed without a read");
  a_sys_gain: assert property (@(posedge mclk) disable iff (rst)
    calibration_control_q.bypassSystemGain |=> !coefUse.useSystemGain)
    else $error("system gain applied while bypassed");
  a_sys_offset: assert property (@(posedge mclk) disable iff (rst)
    !calibration_control_q.bypassSystemOffset |=> coefUse.useSystemOffset)
    else $error("system offset not applied");
  a_self_gain: assert property (@(posedge mclk) disable iff (rst)
    coefUse.useSelfGain == !$past(calibration_control_q.bypassSelfGain))
    else $error("self gain flag wrong");
  a_self_offset: assert property (@(posedge mclk) disable iff (rst)
    coefUse.useSelfOffset == !$past(calibration_control_q.bypassSelfOffset))
    else $error("self offset flag wrong");

  // amplifier
  a_gain_code: assert property (@(posedge mclk) disable iff (rst)
    amp_enable_q && amp_gain_code_q == 3'h7 |=> ampGain == 8'h80)
    else $error("gain code 7 not 128");
  a_gain_power: assert property (@(posedge mclk) disable iff (rst)
    amp_enable_q |=> $onehot(ampGain) && ampGain[$past(amp_gain_code_q)])
    else $error("gain not two to the power of the code");
  a_gain_unity: assert property (@(posedge mclk) disable iff (rst)
    amp_enable_q && amp_gain_code_q == 3'h0 |=> ampGain == acc_pkg::GAIN_ONE)
    else $error("gain code 0 not unity");
  a_amp_off: assert property (@(posedge mclk) disable iff (rst)
    !amp_enable_q |=> ampGain == acc_pkg::GAIN_ONE && !ampEnabled)
    else $error("gain active while amplifier off");
  a_amp_follows: assert property (@(posedge mclk) disable iff (rst)
    ampEnabled == $past(amp_enable_q))
    else $error("amplifier enable output does not follow register");
  a_amp_write: assert property (@(posedge mclk) disable iff (rst)
    regWrite && regSel == acc_pkg::SEL_AMP |=>
      amp_enable_q == $past(regWdata[acc_pkg::AMP_EN_BIT]) && amp_gain_code_q == $past(regWdata[2:0]))
    else $error("amplifier register write lost");
  a_amp_readback: assert property (@(posedge mclk) disable iff (rst)
    regRead && regSel == acc_pkg::SEL_AMP && !regWrite
    |=> regRdata == {4'h0, $past(amp_enable_q), $past(amp_gain_code_q)})
    else $error("amplifier readback mismatch");

  // output pins; the edge that releases reset still shows reset pins, so it is skipped
  a_pins_direct: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) && (seqMode != acc_pkg::SEQ_MODE3 || !calibration_control_q.outSeqSelect)
    |=> general_output_pins == $past(directPins))
    else $error("pins not direct");
  a_pins_mode12: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) && seqMode != acc_pkg::SEQ_MODE3 |=> general_output_pins == $past(directPins))
    else $error("select bit acted outside mode 3");
  a_pins_map: assert property (@(posedge mclk) disable iff (rst)
    seqActive && mapWrite == 1'b0 ##1 seqActive && $stable(activeChannel)
    |=> general_output_pins == $past(mapPinsRd))
    else $error("pins not from map");

  // main scenarios
  c_seq_mode3: cover property (@(posedge mclk) disable iff (rst) seqActive ##1 seqActive);
  c_sync_on: cover property (@(posedge mclk) disable iff (rst) $rose(syncModeOn));
  c_iface_read: cover property (@(posedge mclk) disable iff (rst) coefRead && calibration_control_q.calReadbackSelect);
  c_max_gain: cover property (@(posedge mclk) disable iff (rst) ampGain == 8'h80);
  c_back_to_back: cover property (@(posedge mclk) disable iff (rst) regWrite ##1 regRead);
endmodule // acc_calibration_control_regs

// ==== verification/acc_host_model.sv ====
// host side model: drives the register port of the calibration control block
module acc_host_model (
  input  wire logic       mclk,     // clock
  output logic            regWrite, // write strobe
  output logic            regRead,  // read strobe
  output logic      [1:0] regSel,   // register select
  output logic      [7:0] regWdata, // write data
  input  wire logic [7:0] regRdata  // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regSel   = 2'h0;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [1:0] s, input logic [7:0] w);
    @(posedge mclk);
    regWrite <= 1'b1;
    regSel   <= s;
    regWdata <= w;
    @(posedge mclk);
    regWrite <= 1'b0;
    // data is stale once taken, so show its inverse rather than the old value
    regWdata <= ~w;
  endtask
  // write, then read in the very next cycle
  task automatic wr_rd(input logic [1:0] s, input logic [7:0] w, output logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regSel   <= s;
    regWdata <= w;
    @(posedge mclk);
    regWrite <= 1'b0;
    regWdata <= ~w;
    regRead  <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regSel  <= s;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask
endmodule // acc_host_model

// ==== verification/tb.sv ====
// self-checking bench of the calibration control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       mclk = 1'b0, rst = 1'b1, mapWrite = 1'b0, coefRead = 1'b0;
  logic                       regWrite, regRead, syncModeOn, ampEnabled;
  logic [1:0]                 regSel, seqMode = 2'h3;
  logic [2:0]                 activeChannel = 3'h0, mapChannel = 3'h0;
  logic [5:0]                 mapPins = 6'h00, directPins = 6'h2A, general_output_pins;
  logic [7:0]                 regWdata, regRdata, ampGain, d;
  logic [acc_pkg::COEF_W-1:0] coefIface = 24'hAAAAAA, coefInternal = 24'h555555, coefRdata;
  acc_pkg::acc_coef_use_t     coefUse;
  int                         error_cnt = 0, checked = 0;

  acc_host_model host (.mclk(mclk), .regWrite(regWrite), .regRead(regRead), .regSel(regSel),
    .regWdata(regWdata), .regRdata(regRdata));
  acc_calibration_control_regs dut (.mclk(mclk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regSel(regSel), .regWdata(regWdata), .regRdata(regRdata), .seqMode(seqMode),
    .activeChannel(activeChannel), .mapWrite(mapWrite), .mapChannel(mapChannel), .mapPins(mapPins),
    .directPins(directPins), .coefRead(coefRead), .coefIface(coefIface), .coefInternal(coefInternal),
    .coefRdata(coefRdata), .general_output_pins(general_output_pins), .syncModeOn(syncModeOn),
    .coefUse(coefUse), .ampEnabled(ampEnabled), .ampGain(ampGain));

  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic coef_rd(input logic [23:0] exp);
    @(posedge mclk);
    coefRead <= 1'b1;
    @(posedge mclk);
    coefRead <= 1'b0;
    @(negedge mclk);
    check("coefRdata", exp, coefRdata);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    host.rd(acc_pkg::SEL_CAL, d);
    check("cal reset", 24'h1C, 24'(d));
    check("coefUse reset", 24'h3, 24'(coefUse));
    host.wr(acc_pkg::SEL_CAL, 8'hFF);
    host.rd(acc_pkg::SEL_CAL, d);
    check("cal all ones", 24'h7F, 24'(d));
    check("syncModeOn", 24'h1, 24'(syncModeOn));
    check("coefUse bypass", 24'h0, 24'(coefUse));
    coef_rd(24'hAAAAAA);
    host.wr(acc_pkg::SEL_CAL, 8'h0A);
    host.rd(acc_pkg::SEL_CAL, d);
    check("cal mixed", 24'h0A, 24'(d));
    check("syncModeOn off", 24'h0, 24'(syncModeOn));
    check("coefUse mixed", 24'h5, 24'(coefUse));
    coef_rd(24'h555555);
    for (int c = 0; c < 8; c++) begin
      host.wr(acc_pkg::SEL_AMP, 8'h08 | 8'(c));
      host.rd(acc_pkg::SEL_AMP, d);
      check("ampGain", 24'(8'h01 << c), 24'(ampGain));
      check("ampEnabled", 24'h1, 24'(ampEnabled));
      check("amp readback", 24'(8'h08 | 8'(c)), 24'(d));
    end
    host.wr(acc_pkg::SEL_AMP, 8'h07);
    host.rd(acc_pkg::SEL_AMP, d);
    check("ampGain off", 24'h1, 24'(ampGain));
    check("ampEnabled off", 24'h0, 24'(ampEnabled));
    check("amp readback off", 24'h07, 24'(d));
    host.wr(2'h2, 8'h55);
    host.rd(2'h2, d);
    check("unmapped", 24'h0, 24'(d));
    host.rd(acc_pkg::SEL_CAL, d);
    check("cal kept", 24'h0A, 24'(d));
    host.wr_rd(acc_pkg::SEL_CAL, 8'h25, d);
    check("cal back to back", 24'h25, 24'(d));
    check("syncModeOn back to back", 24'h1, 24'(syncModeOn));
    check("coefUse back to back", 24'hA, 24'(coefUse));
    check("pins direct", 24'h2A, 24'(general_output_pins));
    @(posedge mclk);
    mapWrite <= 1'b1;
    mapChannel <= 3'h2;
    mapPins <= 6'h15;
    @(posedge mclk);
    mapWrite <= 1'b0;
    activeChannel <= 3'h2;
    host.wr(acc_pkg::SEL_CAL, 8'h40);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("pins sequenced", 24'h15, 24'(general_output_pins));
    // sequencing select still set, but modes 1 and 2 must ignore it
    for (int m = 1; m < 3; m++) begin
      @(posedge mclk);
      seqMode <= 2'(m);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check("pins mode 1 2", 24'h2A, 24'(general_output_pins));
    end
    final_report();
  end
endmodule // tb
